// ---- hw/ombx_pkg.sv ----
// Purpose : Shared constants and carrier types for the octal mailbox.
// Assumes : One system clock; capture clock arrives as a sampled input.
// Notes   : Word width and flag reset value live here.
package ombx_pkg;

  localparam int          OMBX_WORD_W    = 8;
  localparam logic        OMBX_FLAG_RST  = 1'b0;
  localparam logic        OMBX_EDGE_RST  = 1'b1;
  localparam logic [7:0]  OMBX_WORD_RST  = 8'h00;
  localparam int          OMBX_TOP_BIT   = OMBX_WORD_W - 1;

  // Writer side: word, flag and active-low load enable
  typedef struct packed {
    logic [OMBX_WORD_W-1:0] word_in;
    logic                   ready_flag_in;
    logic                   load_en_n;
  } ombx_wr_t;

  // Reader side: the two active-low output enables
  typedef struct packed {
    logic data_drive_en_n;
    logic status_route_en_n;
  } ombx_rd_t;

  // Whole block state
  typedef struct packed {
    logic [OMBX_WORD_W-1:0] word;
    logic                   flag;
    logic                   clk_prev;
  } ombx_state_t;

endpackage : ombx_pkg

// ---- hw/ombx_mailbox.sv ----
// Purpose : Eight-bit mailbox register with ready flag and read-clear.
// Assumes : capture_clock, enables and data are synchronous to clk_i.
// Notes   : Tri-state data pins are split into value and per-bit enable;
//           the open-collector flag is an active-low pull enable.
//           A word read clears the flag even against a load of it.
`timescale 1ns/10ps

module ombx_mailbox
  import ombx_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // Writer side
  input  wire logic                    capture_clock_i,
  input  wire ombx_pkg::ombx_wr_t      wr_i,
  // Reader side
  input  wire ombx_pkg::ombx_rd_t      rd_i,
  output logic [ombx_pkg::OMBX_WORD_W-1:0] word_out_o,
  output logic [ombx_pkg::OMBX_WORD_W-1:0] word_out_oe_o,
  output logic                         ready_flag_out_oc_o,
  output logic                         ready_flag_out_oc_oe_o
);
  import ombx_pkg::*;

  // **********************************************************
  // State update
  // **********************************************************
  ombx_state_t state;
  ombx_state_t next_state;
  logic        cap_edge;
  logic        read_word;
  logic        poll_flag;

  always_comb
  begin
    next_state          = state;
    next_state.clk_prev = capture_clock_i;
    // A capture pulse shorter than one clk_i period can fall between edges and go unseen
    // rising edge only; enable is sampled, not gated
    cap_edge  = capture_clock_i && !state.clk_prev;
    read_word = !rd_i.data_drive_en_n && !rd_i.status_route_en_n;
    poll_flag = !rd_i.data_drive_en_n && rd_i.status_route_en_n;
    // capture with load enable low, else hold
    if (cap_edge && !wr_i.load_en_n)
    begin
      next_state.word = wr_i.word_in;
      next_state.flag = wr_i.ready_flag_in;
    end
    // read clears flag and overrides a concurrent load of the flag; the word still loads
    if (read_word)
    begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state.word     <= OMBX_WORD_RST;
      state.flag     <= OMBX_FLAG_RST;
      // History starts high: a capture clock already high at release is
      // not an edge, at the price of missing a rise on the first edge.
      state.clk_prev <= OMBX_EDGE_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // **********************************************************
  // Output pins
  // **********************************************************
  // Whole-word read shows the word; polling shows the flag on the top bit.
  // Flag reads combinationally so a poll sees the live stored value.
  always_comb
  begin
    word_out_o    = state.word;
    word_out_oe_o = '0;
    if (read_word)
    begin
      word_out_oe_o = '1;
    end
    else if (poll_flag)
    begin
      word_out_o[OMBX_TOP_BIT]    = state.flag;
      word_out_oe_o[OMBX_TOP_BIT] = 1'b1;
    end
  end

  // open collector pulls low while flag is low
  // Pin only ever pulls low; a released line reads high via the pull-up
  assign ready_flag_out_oc_o    = 1'b0;
  assign ready_flag_out_oc_oe_o = !state.flag;

  // **********************************************************
  // Checks
  // **********************************************************
  // One clock domain, so the checks share one clock; all but the reset checks share one reset guard
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // A rise seen on the first edge after reset is refused by design
  chk_load_capture: assert property (
    (capture_clock_i && !$past(capture_clock_i) && !$past(reset_i)
     && !wr_i.load_en_n && !read_word)
     |=> (state.word == $past(wr_i.word_in)
     && state.flag == $past(wr_i.ready_flag_in)))
    else $error("load did not capture word and flag");

  chk_no_edge_hold: assert property (
    !(capture_clock_i && !state.clk_prev) && !read_word
    |=> $stable(state.word) && $stable(state.flag))
    else $error("storage changed without a rising edge");

  chk_disabled_hold: assert property (
    wr_i.load_en_n |=> $stable(state.word))
    else $error("word changed while load disabled");

  chk_flag_hold: assert property (
    wr_i.load_en_n && !read_word |=> $stable(state.flag))
    else $error("flag changed while load disabled");

  chk_word_on_read: assert property (
    read_word && !capture_clock_i |=> $stable(state.word))
    else $error("word read changed the stored word");

  chk_high_clock_hold: assert property (
    capture_clock_i && $past(capture_clock_i) && !read_word
    |=> $stable(state.word) && $stable(state.flag))
    else $error("storage changed while capture clock stayed high");

  chk_float_all: assert property (
    rd_i.data_drive_en_n |-> word_out_oe_o == '0)
    else $error("data driven while first enable high");

  chk_drive_needs_en: assert property (
    word_out_oe_o != '0 |-> !rd_i.data_drive_en_n)
    else $error("data pin driven with first enable high");

  chk_low_bits_en: assert property (
    (|word_out_oe_o[OMBX_TOP_BIT-1:0])
    |-> !rd_i.data_drive_en_n && !rd_i.status_route_en_n)
    else $error("low data bits driven outside a word read");

  chk_poll_route: assert property (
    poll_flag |-> word_out_oe_o == 8'h80
    && word_out_o[OMBX_TOP_BIT] == state.flag)
    else $error("poll mode wrong routing");

  chk_poll_keeps: assert property (
    poll_flag && !capture_clock_i |=> $stable(state.flag))
    else $error("status poll changed the flag");

  chk_read_clear: assert property (
    read_word |=> !state.flag)
    else $error("flag not cleared by word read");

  chk_load_during_read: assert property (
    capture_clock_i && !$past(capture_clock_i) && !$past(reset_i)
    && !wr_i.load_en_n && read_word
    |=> state.word == $past(wr_i.word_in) && !state.flag)
    else $error("load during word read kept the flag");

  chk_read_drive: assert property (
    read_word |-> word_out_oe_o == 8'hFF && word_out_o == state.word)
    else $error("word read did not drive stored word");

  chk_flag_pin: assert property (
    ready_flag_out_oc_oe_o == !state.flag && !ready_flag_out_oc_o)
    else $error("flag pin disagrees with stored flag");

  chk_read_pin: assert property (
    read_word |=> ready_flag_out_oc_oe_o)
    else $error("flag pin released after word read");

  // Reset checks must not be switched off by the reset they watch
  chk_reset_flag: assert property (@(posedge clk_i)
    disable iff (1'b0) reset_i |=> !state.flag)
    else $error("flag not clear after reset");

  chk_reset_pin: assert property (@(posedge clk_i)
    disable iff (1'b0) reset_i |=> ready_flag_out_oc_oe_o)
    else $error("flag pin released after reset");

  chk_reset_word: assert property (@(posedge clk_i)
    disable iff (1'b0) reset_i |=> state.word == OMBX_WORD_RST)
    else $error("word not cleared by reset");

  // **********************************************************
  // Coverage
  // **********************************************************
  cov_load_flag: cover property (cap_edge && !wr_i.load_en_n
    && wr_i.ready_flag_in ##2 poll_flag);
  cov_read_clear: cover property (state.flag ##1 read_word ##1 !state.flag);
  cov_load_during_read: cover property (cap_edge && !wr_i.load_en_n
    && read_word);
  cov_poll_empty: cover property (poll_flag && !state.flag);
  cov_enable_toggle: cover property (capture_clock_i && state.clk_prev
    && $changed(wr_i.load_en_n));

endmodule : ombx_mailbox

// ---- dv/ombx_reader.sv ----
// Purpose : Reader-side model of the open-collector flag line.
// Assumes : The line has a pull-up resistor.
// Notes   : A released line reads high, never the last driven level.
`timescale 1ns/10ps
module ombx_reader
(
  // Device pin
  input  wire logic oc_i,
  input  wire logic oc_oe_i,
  // Level seen by the reader
  output logic      flag_line_o
);
  assign flag_line_o = oc_oe_i ? oc_i : 1'b1;
endmodule : ombx_reader

// ---- dv/ombx_tb.sv ----
// Purpose : Self-checking bench for the mailbox register.
// Assumes : Bench plays writer; ombx_reader models the flag pull-up.
// Notes   : Floating data bits are masked before compare.
`timescale 1ns/10ps
module octal_mailbox_register_with_flag_tb;
  import ombx_pkg::*;
  logic       clk_i   = 1'b0;
  logic       reset_i = 1'b1;
  logic       cc      = 1'b0;
  ombx_wr_t   wr      = '{8'h00, 1'b0, 1'b1};
  ombx_rd_t   rd      = 2'h3;
  logic [7:0] wo, woe;
  logic       oc, ocoe, fl;
  ombx_wr_t   bwr       = '{8'h00, 1'b0, 1'b1};
  ombx_rd_t   brd       = 2'h3;
  logic [7:0] bwo, bwoe;
  logic       boc, bocoe, bfl;
  logic       look_back = 1'b0;
  logic [8:0] rows [4] = '{9'h14B, 9'h0B4, 9'h1FF, 9'h001};
  int         mismatches = 0;
  int         checked    = 0;
  always #20 clk_i = ~clk_i;
  ombx_mailbox u_ombx_mailbox (.clk_i(clk_i), .reset_i(reset_i),
    .capture_clock_i(cc), .wr_i(wr), .rd_i(rd), .word_out_o(wo),
    .word_out_oe_o(woe), .ready_flag_out_oc_o(oc),
    .ready_flag_out_oc_oe_o(ocoe));
  ombx_reader u_ombx_reader (.oc_i(oc), .oc_oe_i(ocoe), .flag_line_o(fl));
  // second mailbox carries replies the other way
  ombx_mailbox u_ombx_mailbox_back (.clk_i(clk_i), .reset_i(reset_i),
    .capture_clock_i(cc), .wr_i(bwr), .rd_i(brd), .word_out_o(bwo),
    .word_out_oe_o(bwoe), .ready_flag_out_oc_o(boc),
    .ready_flag_out_oc_oe_o(bocoe));
  ombx_reader u_ombx_reader_back (.oc_i(boc), .oc_oe_i(bocoe),
    .flag_line_o(bfl));
  task automatic chk(input logic [16:0] exp);
    logic [16:0] act;
    act = look_back ? {bwoe, bwo & bwoe, bfl} : {woe, wo & woe, fl};
    checked++;
    if (act !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t pins %h expected %h", $time, act, exp);
    end
  endtask : chk
  // Writer: low sample, then rising capture clock
  task automatic cap(input logic [7:0] w, input logic f, len);
    @(posedge clk_i) cc <= 1'b0;
    wr <= '{w, f, len};
    @(posedge clk_i) cc <= 1'b1;
    @(posedge clk_i) cc <= 1'b0;
    #1;
  endtask : cap
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i) #1;
    chk(17'h0);
    foreach (rows[i])
    begin
      cap(rows[i][8:1], rows[i][0], 1'b0);
      chk({16'h0, rows[i][0]});
      @(posedge clk_i) rd <= 2'h1;
      #1 chk({8'h80, rows[i][0], 7'h0, rows[i][0]});
      @(posedge clk_i) rd <= 2'h0;
      #1 chk({8'hFF, rows[i][8:1], rows[i][0]});
      @(posedge clk_i) rd <= 2'h3;
      #1 chk(17'h0);
    end
    cap(8'h3C, 1'b1, 1'b1);
    chk(17'h0);
    cap(8'hC3, 1'b1, 1'b0);
    cc <= 1'b1;
    wr <= '{8'h11, 1'b1, 1'b0};
    @(posedge clk_i) wr <= '{8'h11, 1'b1, 1'b1};
    @(posedge clk_i) wr <= '{8'h11, 1'b1, 1'b0};
    @(posedge clk_i) rd <= 2'h0;
    #1 chk({8'hFF, 8'hC3, 1'b1});
    @(posedge clk_i) #1 chk({8'hFF, 8'hC3, 1'b0});
    cap(8'h96, 1'b1, 1'b0);
    chk({8'hFF, 8'h96, 1'b0});
    rd <= 2'h3;
    bwr <= '{8'h5A, 1'b1, 1'b0};
    cap(8'h96, 1'b0, 1'b1);
    chk(17'h0);
    bwr <= '{8'h5A, 1'b1, 1'b1};
    look_back = 1'b1;
    chk({16'h0, 1'b1});
    @(posedge clk_i) brd <= 2'h0;
    #1 chk({8'hFF, 8'h5A, 1'b1});
    @(posedge clk_i) brd <= 2'h3;
    #1 chk(17'h0);
    look_back = 1'b0;
    cap(8'h69, 1'b1, 1'b0);
    reset_i <= 1'b1;
    @(posedge clk_i) reset_i <= 1'b0;
    #1 chk(17'h0);
    summarize();
  end
endmodule : octal_mailbox_register_with_flag_tb
